// [hw/swr_pin_change.sv]
// Pin-change detector: compares pins against the value latched at the last capture.
// Assumes pins are synchronous to the clock.
`timescale 1ns/100ps
`default_nettype none
module swr_pin_change #(
   parameter int N = swr_pkg::WAKE_PINS
) (
   input  wire logic         clock,
   input  wire logic         resetn,
   input  wire logic [N-1:0] pins,
   input  wire logic         capture,
   output logic              mismatch
);
   typedef struct packed {
      logic [N-1:0] ref_val;
      logic         mismatch;
   } swr_pc_s;

   swr_pc_s      q_ff;
   swr_pc_s      nxt_q;
   logic [N-1:0] diff;

   genvar i;
   generate
      for (i = 0; i < N; i++) begin : g_bit
         assign diff[i] = pins[i] ^ q_ff.ref_val[i];
      end
   endgenerate

   always_comb begin
      nxt_q = q_ff;
      if (capture) begin
         nxt_q.ref_val  = pins;
         nxt_q.mismatch = 1'b0;
      end else begin
         // Sticky until the next capture, so re-entering sleep wakes at once
         nxt_q.mismatch = q_ff.mismatch | (|diff);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign mismatch = q_ff.mismatch;
endmodule : swr_pin_change
`default_nettype wire

// [hw/swr_pkg.sv]
// Constants, field positions and carrier types for the sleep wake-up reset logic.
// Assumes one 100 MHz clock and a 32-bit classic Wishbone register bus.
package swr_pkg;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam int           ADDR_W        = 5;
   localparam logic [4:0]   ADDR_CTRL     = 5'h00;
   localparam logic [4:0]   ADDR_CFG      = 5'h04;
   localparam logic [4:0]   ADDR_STATUS   = 5'h08;
   localparam logic [4:0]   ADDR_PORT     = 5'h0c;
   localparam logic [4:0]   ADDR_IRQ_STAT = 5'h10;
   localparam logic [4:0]   ADDR_IRQ_MASK = 5'h14;
   localparam logic [4:0]   ADDR_STATE    = 5'h18;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int           CTRL_SLEEP    = 0;
   localparam int           CTRL_CLRWDT   = 1;
   localparam int           CFG_MASTER_CLEAR_PIN_EN   = 0;
   localparam int           CFG_WDT_EN    = 1;
   localparam int           CFG_WOC_EN    = 2;
   localparam int           ST_PD_N       = 3;
   localparam int           ST_TO_N       = 4;
   localparam int           ST_PCWF       = 7;
   localparam int           PORT_P0       = 0;
   localparam int           PORT_P1       = 1;
   localparam int           PORT_P3       = 3;
   localparam int           IRQ_W         = 4;
   localparam int           IRQ_MASTER_CLEAR_PIN      = 0;
   localparam int           IRQ_WDT       = 1;
   localparam int           IRQ_PIN       = 2;
   localparam int           IRQ_SLEEP     = 3;
   localparam int           WAKE_PINS     = 3;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [2:0]   CFG_RESET     = 3'h3;
   localparam logic [3:0]   MASK_RESET    = 4'h0;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int           CLK_MHZ       = 100;
   localparam int           WDT_PERIOD_US = 18000;
   localparam int           WDT_CYCLES    = WDT_PERIOD_US * CLK_MHZ;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      SWR_RUN   = 2'b01,
      SWR_SLEEP = 2'b10
   } swr_mode_e;

   typedef struct packed {
      logic woc_en;
      logic wdt_en;
      logic master_clear_pin_en;
   } swr_cfg_s;

   typedef struct packed {
      logic pin_change_wake_flag;
      logic watchdog_expiry_flag_n;
      logic sleep_entered_flag_n;
   } swr_flags_s;

endpackage : swr_pkg

// [hw/swr_sleep_wakeup_reset_cause.sv]
// Sleep exit logic: watches wake sources, issues device reset, records the cause.
// Assumes a classic Wishbone master, synchronous port pins, resetn is power-on.
`timescale 1ns/100ps
`default_nettype none

// How it works
// [RL1] Wake on master clear when enabled
// [RL2] Wake on watchdog expiry when enabled
// [RL3] Wake on pin 0/1/3 change if enabled
// [RL4] Every wake issues full device reset
// [RL5] Watchdog time-out clears expiry flag
// [RL6] Power-up sets, sleep clears power-down flag
// [RL7] Pin change in sleep sets wake flag
// [RL8] Unread mismatch wakes at once on resleep
// [RL9] Waking clears the watchdog counter
// [RL10] Sleep clears watchdog, sets expiry flag, clears power-down flag, stops oscillator
// [RL11] Master clear awake keeps flags, clears pin-flag
// [RL12] Port access re-arms change reference
module swr_sleep_wakeup_reset_cause #(
   parameter int WDT_CYCLES = swr_pkg::WDT_CYCLES
) (
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [4:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   input  wire logic        port_pin_0,
   input  wire logic        port_pin_1,
   input  wire logic        port_pin_3,
   output logic             device_reset,
   output logic             osc_driver_on,
   output logic             port_hold,
   output logic             sleeping,
   output logic             irq
);

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   typedef struct packed {
      swr_pkg::swr_mode_e   mode;
      swr_pkg::swr_cfg_s    cfg;
      swr_pkg::swr_flags_s  flags;
      logic [swr_pkg::IRQ_W-1:0] irq_stat;
      logic [swr_pkg::IRQ_W-1:0] irq_mask;
      logic                 master_clear_pin_prev;
      logic                 ack;
      logic [31:0]          dat;
      logic                 dev_reset;
   } swr_state_s;

   swr_state_s q_ff;
   swr_state_s nxt_q;

   logic       access;
   logic       wr;
   logic       sleep_cmd;
   logic       clrwdt_cmd;
   logic       port_access;
   logic       master_clear_pin_low;
   logic       wdt_expire;
   logic       mismatch;
   logic       wake_master_clear_pin;
   logic       wake_wdt;
   logic       wake_pin;
   logic       wake;
   logic       wdt_clear;
   logic [2:0] pins;
   logic [swr_pkg::IRQ_W-1:0] events;

   assign pins = {port_pin_3, port_pin_1, port_pin_0};

   // ------------------------------------------------------------
   // Bus decode
   // ------------------------------------------------------------
   // Actions happen at the edge that raises ack, one per request
   assign access     = wb_cyc_i & wb_stb_i & ~q_ff.ack;
   assign wr         = access & wb_we_i & wb_sel_i[0];
   assign sleep_cmd  = wr && wb_adr_i == swr_pkg::ADDR_CTRL
                       && wb_dat_i[swr_pkg::CTRL_SLEEP]
                       && q_ff.mode == swr_pkg::SWR_RUN;
   assign clrwdt_cmd = wr && wb_adr_i == swr_pkg::ADDR_CTRL
                       && wb_dat_i[swr_pkg::CTRL_CLRWDT]
                       && q_ff.mode == swr_pkg::SWR_RUN;
   // [RL12] Any port access
   assign port_access = access && wb_adr_i == swr_pkg::ADDR_PORT;

   // ------------------------------------------------------------
   // Wake sources
   // ------------------------------------------------------------
   // Pin 3 doubles as the active-low master clear input
   assign master_clear_pin_low  = q_ff.cfg.master_clear_pin_en & ~port_pin_3;
   // [RL1] Master clear wake
   assign wake_master_clear_pin = q_ff.mode == swr_pkg::SWR_SLEEP && master_clear_pin_low;
   // [RL2] Watchdog wake
   assign wake_wdt  = q_ff.mode == swr_pkg::SWR_SLEEP && wdt_expire && !wake_master_clear_pin;
   // [RL3] [RL8] Pending mismatch wakes
   assign wake_pin  = q_ff.mode == swr_pkg::SWR_SLEEP && q_ff.cfg.woc_en
                      && mismatch && !wake_master_clear_pin && !wake_wdt;
   assign wake      = wake_master_clear_pin | wake_wdt | wake_pin;
   // [RL9] [RL10] Watchdog cleared on sleep and wake
   assign wdt_clear = sleep_cmd | clrwdt_cmd | wake;

   swr_watchdog #(
      .CYCLES (WDT_CYCLES)
   ) u_watchdog (
      .clock  (clock),
      .resetn (resetn),
      .enable (q_ff.cfg.wdt_en),
      .clear  (wdt_clear),
      .expire (wdt_expire)
   );

   swr_pin_change #(
      .N (swr_pkg::WAKE_PINS)
   ) u_pin_change (
      .clock    (clock),
      .resetn   (resetn),
      .pins     (pins),
      .capture  (port_access),
      .mismatch (mismatch)
   );

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      nxt_q           = q_ff;
      nxt_q.ack       = access;
      nxt_q.dev_reset = 1'b0;
      nxt_q.master_clear_pin_prev = master_clear_pin_low;
      events          = '0;

      case (q_ff.mode)
         swr_pkg::SWR_RUN: begin
            if (master_clear_pin_low && !q_ff.master_clear_pin_prev) begin
               // [RL11] Awake master clear
               nxt_q.dev_reset                  = 1'b1;
               nxt_q.flags.pin_change_wake_flag = 1'b0;
               events[swr_pkg::IRQ_MASTER_CLEAR_PIN]        = 1'b1;
            end else if (wdt_expire) begin
               // [RL5] Awake time-out, power-down unchanged
               nxt_q.dev_reset                    = 1'b1;
               nxt_q.flags.watchdog_expiry_flag_n = 1'b0;
               nxt_q.flags.pin_change_wake_flag   = 1'b0;
               events[swr_pkg::IRQ_WDT]           = 1'b1;
            end else if (sleep_cmd) begin
               // [RL6] [RL10] Sleep entry
               nxt_q.mode                         = swr_pkg::SWR_SLEEP;
               nxt_q.flags.watchdog_expiry_flag_n = 1'b1;
               nxt_q.flags.sleep_entered_flag_n   = 1'b0;
               events[swr_pkg::IRQ_SLEEP]         = 1'b1;
            end else if (clrwdt_cmd) begin
               nxt_q.flags.watchdog_expiry_flag_n = 1'b1;
               nxt_q.flags.sleep_entered_flag_n   = 1'b1;
            end
         end
         swr_pkg::SWR_SLEEP: begin
            if (wake) begin
               // [RL4] Reset, never resume
               nxt_q.mode      = swr_pkg::SWR_RUN;
               nxt_q.dev_reset = 1'b1;
            end
            if (wake_master_clear_pin) begin
               nxt_q.flags.pin_change_wake_flag = 1'b0;
               events[swr_pkg::IRQ_MASTER_CLEAR_PIN]        = 1'b1;
            end
            if (wake_wdt) begin
               // [RL5] Time-out ends sleep
               nxt_q.flags.watchdog_expiry_flag_n = 1'b0;
               nxt_q.flags.pin_change_wake_flag   = 1'b0;
               events[swr_pkg::IRQ_WDT]           = 1'b1;
            end
            if (wake_pin) begin
               // [RL7] Pin change cause
               nxt_q.flags.pin_change_wake_flag   = 1'b1;
               nxt_q.flags.watchdog_expiry_flag_n = 1'b1;
               nxt_q.flags.sleep_entered_flag_n   = 1'b0;
               events[swr_pkg::IRQ_PIN]           = 1'b1;
            end
         end
         default: begin
            nxt_q.mode = swr_pkg::SWR_RUN;
         end
      endcase

      // Register writes; the mask and enables survive a device reset
      if (wr && wb_adr_i == swr_pkg::ADDR_CFG) begin
         nxt_q.cfg.master_clear_pin_en = wb_dat_i[swr_pkg::CFG_MASTER_CLEAR_PIN_EN];
         nxt_q.cfg.wdt_en  = wb_dat_i[swr_pkg::CFG_WDT_EN];
         nxt_q.cfg.woc_en  = wb_dat_i[swr_pkg::CFG_WOC_EN];
      end
      if (wr && wb_adr_i == swr_pkg::ADDR_IRQ_MASK) begin
         nxt_q.irq_mask = wb_dat_i[swr_pkg::IRQ_W-1:0];
      end

      // Read data, captured with the ack
      nxt_q.dat = '0;
      if (access && !wb_we_i) begin
         case (wb_adr_i)
            swr_pkg::ADDR_CFG: begin
               nxt_q.dat[swr_pkg::CFG_MASTER_CLEAR_PIN_EN] = q_ff.cfg.master_clear_pin_en;
               nxt_q.dat[swr_pkg::CFG_WDT_EN]  = q_ff.cfg.wdt_en;
               nxt_q.dat[swr_pkg::CFG_WOC_EN]  = q_ff.cfg.woc_en;
            end
            swr_pkg::ADDR_STATUS: begin
               nxt_q.dat[swr_pkg::ST_PCWF] = q_ff.flags.pin_change_wake_flag;
               nxt_q.dat[swr_pkg::ST_TO_N] = q_ff.flags.watchdog_expiry_flag_n;
               nxt_q.dat[swr_pkg::ST_PD_N] = q_ff.flags.sleep_entered_flag_n;
            end
            swr_pkg::ADDR_PORT: begin
               nxt_q.dat[swr_pkg::PORT_P0] = port_pin_0;
               nxt_q.dat[swr_pkg::PORT_P1] = port_pin_1;
               nxt_q.dat[swr_pkg::PORT_P3] = port_pin_3;
            end
            swr_pkg::ADDR_IRQ_STAT: begin
               nxt_q.dat[swr_pkg::IRQ_W-1:0] = q_ff.irq_stat;
            end
            swr_pkg::ADDR_IRQ_MASK: begin
               nxt_q.dat[swr_pkg::IRQ_W-1:0] = q_ff.irq_mask;
            end
            swr_pkg::ADDR_STATE: begin
               nxt_q.dat[1:0] = q_ff.mode;
               nxt_q.dat[2]   = mismatch;
            end
            default: begin
               nxt_q.dat = '0;
            end
         endcase
      end

      // Read clears sticky bits; an event in the same cycle still lands
      if (access && !wb_we_i && wb_adr_i == swr_pkg::ADDR_IRQ_STAT) begin
         nxt_q.irq_stat = events;
      end else begin
         nxt_q.irq_stat = q_ff.irq_stat | events;
      end
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q_ff.mode      <= swr_pkg::SWR_RUN;
         q_ff.cfg       <= swr_pkg::CFG_RESET;
         // [RL6] Power-up flag values
         q_ff.flags     <= 3'b011;
         q_ff.irq_stat  <= '0;
         q_ff.irq_mask  <= swr_pkg::MASK_RESET;
         q_ff.master_clear_pin_prev <= 1'b0;
         q_ff.ack       <= 1'b0;
         q_ff.dat       <= '0;
         q_ff.dev_reset <= 1'b0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack_o      = q_ff.ack;
   assign wb_dat_o      = q_ff.dat;
   assign device_reset  = q_ff.dev_reset;
   assign sleeping      = q_ff.mode == swr_pkg::SWR_SLEEP;
   // [RL10] Oscillator off, ports held
   assign osc_driver_on = ~sleeping;
   assign port_hold     = sleeping;
   assign irq           = |(q_ff.irq_stat & q_ff.irq_mask);

endmodule : swr_sleep_wakeup_reset_cause
`default_nettype wire

// [hw/swr_watchdog.sv]
// Watchdog counter: counts clock cycles while enabled, pulses on expiry.
// Assumes the owner clears it on sleep, on a clear command and on wake.
`timescale 1ns/100ps
`default_nettype none
module swr_watchdog #(
   parameter int CYCLES = swr_pkg::WDT_CYCLES
) (
   input  wire logic clock,
   input  wire logic resetn,
   input  wire logic enable,
   input  wire logic clear,
   output logic      expire
);
   localparam int CW = $clog2(CYCLES + 1);
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic          expire;
   } swr_wdt_s;

   swr_wdt_s q_ff;
   swr_wdt_s nxt_q;

   always_comb begin
      nxt_q        = q_ff;
      nxt_q.expire = 1'b0;
      if (clear || !enable) begin
         nxt_q.cnt = '0;
      end else if (q_ff.cnt == LAST) begin
         nxt_q.cnt    = '0;
         nxt_q.expire = 1'b1;
      end else begin
         nxt_q.cnt = q_ff.cnt + CW'(1);
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         q_ff <= '0;
      end else begin
         q_ff <= nxt_q;
      end
   end

   assign expire = q_ff.expire;
endmodule : swr_watchdog
`default_nettype wire

// [testbench/swr_checker_asserts.sv]
// Concurrent checks on the ports of the sleep wake-up reset block.
// Assumes a classic Wishbone master that drops cyc and stb after each ack.
`timescale 1ns/100ps
`default_nettype none
module swr_checker #(
   parameter int WDT_CYCLES = 20
) (
   input wire logic        clock,
   input wire logic        resetn,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [4:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        port_pin_0,
   input wire logic        port_pin_1,
   input wire logic        port_pin_3,
   input wire logic        device_reset,
   input wire logic        osc_driver_on,
   input wire logic        port_hold,
   input wire logic        sleeping,
   input wire logic        irq
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);
   wire taken = wb_cyc_i && wb_stb_i && !wb_ack_o;
   wire ctrl  = wb_adr_i == swr_pkg::ADDR_CTRL;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   ack_answer_a: assert property (taken |=> wb_ack_o)
      else $error("request not answered in one cycle");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   rst_pulse_a: assert property (device_reset |=> !device_reset)
      else $error("device reset longer than one cycle");
   wake_reset_a: assert property ($fell(sleeping) |-> device_reset)
      else $error("wake without device reset");
   sleep_enter_a: assert property (taken && wb_we_i && wb_sel_i[0] && wb_dat_i[0] && ctrl
      && !sleeping |=> sleeping)
      else $error("sleep command not taken");
   sleep_pins_a: assert property (sleeping |-> !osc_driver_on && port_hold)
      else $error("oscillator or port hold wrong in sleep");
   awake_pins_a: assert property (!sleeping |-> osc_driver_on && !port_hold)
      else $error("oscillator or port hold wrong awake");
   ctrl_read_a: assert property (taken && !wb_we_i && ctrl |=> wb_dat_o == 32'h0)
      else $error("control register reads nonzero");
   sleep_c: cover property (taken && wb_we_i && ctrl && wb_dat_i[0]);
   wake_c: cover property ($fell(sleeping));
   irq_c: cover property ($rose(irq));
endmodule : swr_checker

bind swr_sleep_wakeup_reset_cause swr_checker #(.WDT_CYCLES(WDT_CYCLES)) swr_checker_i (
   .clock(clock), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .port_pin_0(port_pin_0),
   .port_pin_1(port_pin_1), .port_pin_3(port_pin_3), .device_reset(device_reset),
   .osc_driver_on(osc_driver_on), .port_hold(port_hold), .sleeping(sleeping), .irq(irq));
`default_nettype wire

// [testbench/tb_sleep_wakeup_reset_cause.sv]
// Self-checking bench for the sleep wake-up reset block.
// Assumes the block acks one cycle after a request and pulses device_reset on wake.
`timescale 1ns/100ps
`default_nettype none
`define check_eq(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module tb_sleep_wakeup_reset_cause;
   logic        clock, resetn, cyc, stb, we, ack, dev_rst, osc_on, hold, sleeping, irq;
   logic [4:0]  adr;
   logic [3:0]  sel;
   logic [2:0]  pv;
   logic [31:0] dat_i, dat_o, q;
   int          n_errors = 0, checks = 0, seed = 32'ha433, k;

   // Short watchdog so a timed wake fits the run
   swr_sleep_wakeup_reset_cause #(.WDT_CYCLES(40)) swr_sleep_wakeup_reset_cause_i (
      .clock(clock), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .port_pin_0(pv[0]), .port_pin_1(pv[1]), .port_pin_3(pv[2]), .device_reset(dev_rst),
      .osc_driver_on(osc_on), .port_hold(hold), .sleeping(sleeping), .irq(irq));

   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end

   // ------------------------------------------------------------
   // Model and tasks
   // ------------------------------------------------------------
   function automatic logic [31:0] st_word(input int pc, input int to, input int pd);
      return {24'h0, pc[0], 2'h0, to[0], pd[0], 3'h0};
   endfunction : st_word

   // Reference model of the cause flags and the sticky event bits
   int          m_pc = 0, m_to = 1, m_pd = 1;
   int          ev_q[$];

   // Event codes follow the event bit layout; IRQ_W stands for clear watchdog
   task automatic model_ev(input int ev);
      if (ev < swr_pkg::IRQ_W) begin
         ev_q.push_back(ev);
      end
      case (ev)
         swr_pkg::IRQ_MASTER_CLEAR_PIN: begin
            m_pc = 0;
         end
         swr_pkg::IRQ_WDT: begin
            m_pc = 0;
            m_to = 0;
         end
         swr_pkg::IRQ_PIN: begin
            m_pc = 1;
            m_to = 1;
            m_pd = 0;
         end
         swr_pkg::IRQ_SLEEP: begin
            m_to = 1;
            m_pd = 0;
         end
         default: begin
            m_to = 1;
            m_pd = 1;
         end
      endcase
   endtask : model_ev

   task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clock);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_i <= d;
      sel <= 4'hf;
      do begin
         @(posedge clock);
         n++;
      end while (ack !== 1'b1 && n < 50);
      if (n >= 50) n_errors++;
      q = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask : wb

   task automatic rd_chk(input logic [4:0] a, input logic [31:0] e);
      wb(1'b0, a, 32'h0);
      `check_eq(q, e)
   endtask : rd_chk

   // Read-clear of the sticky events, expected value from the model queue
   task automatic irq_chk;
      logic [31:0] e = 32'h0;
      while (ev_q.size() > 0) begin
         e[ev_q.pop_front()] = 1'b1;
      end
      rd_chk(swr_pkg::ADDR_IRQ_STAT, e);
   endtask : irq_chk

   task automatic go_sleep;
      wb(1'b1, swr_pkg::ADDR_CTRL, 32'h1);
      model_ev(swr_pkg::IRQ_SLEEP);
   endtask : go_sleep

   // Sampled just after the edge, so a pulse at the ack edge is not missed
   task automatic wait_rst(input int lim, input int ev);
      int n = 0;
      #1;
      while (dev_rst !== 1'b1 && n < lim) begin
         @(posedge clock);
         #1;
         n++;
      end
      `check_eq(dev_rst, 1'b1)
      model_ev(ev);
   endtask : wait_rst

   task automatic tally_and_finish;
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : tally_and_finish

   initial begin
      repeat (5000) @(posedge clock);
      n_errors++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      {cyc, stb, we, adr, sel, dat_i, resetn} = '0;
      pv = {1'b1, 2'($random(seed))};
      repeat (20) @(posedge clock);
      resetn <= 1'b1;
      rd_chk(swr_pkg::ADDR_CFG, 32'h3);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      wb(1'b1, swr_pkg::ADDR_CFG, 32'h4);
      wb(1'b1, swr_pkg::ADDR_IRQ_MASK, 32'h4);
      for (k = 0; k < 3; k++) begin
         irq_chk();
         rd_chk(swr_pkg::ADDR_PORT, {28'h0, pv[2], 1'b0, pv[1:0]});
         go_sleep();
         `check_eq(osc_on, 1'b0)
         `check_eq(hold, 1'b1)
         pv[k] <= ~pv[k];
         wait_rst(10, swr_pkg::IRQ_PIN);
         rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
         `check_eq(irq, 1'b1)
         irq_chk();
         `check_eq(irq, 1'b0)
      end
      pv[2] <= 1'b1;
      wb(1'b1, swr_pkg::ADDR_CFG, 32'h5);
      pv[2] <= 1'b0;
      wait_rst(10, swr_pkg::IRQ_MASTER_CLEAR_PIN);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      pv[2] <= 1'b1;
      rd_chk(swr_pkg::ADDR_STATE, 32'h5);
      go_sleep();
      wait_rst(3, swr_pkg::IRQ_PIN);
      wb(1'b0, swr_pkg::ADDR_PORT, 32'h0);
      go_sleep();
      rd_chk(swr_pkg::ADDR_STATE, 32'h2);
      pv[2] <= 1'b0;
      wait_rst(10, swr_pkg::IRQ_MASTER_CLEAR_PIN);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      pv[2] <= 1'b1;
      wb(1'b1, swr_pkg::ADDR_CFG, 32'h2);
      irq_chk();
      wb(1'b0, swr_pkg::ADDR_PORT, 32'h0);
      go_sleep();
      repeat (10) @(posedge clock);
      `check_eq(sleeping, 1'b1)
      wait_rst(50, swr_pkg::IRQ_WDT);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      `check_eq(irq, 1'b0)
      irq_chk();
      wb(1'b1, swr_pkg::ADDR_CFG, 32'h0);
      wb(1'b1, swr_pkg::ADDR_CTRL, 32'h2);
      model_ev(swr_pkg::IRQ_W);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      // Awake time-out: reset without sleep, power-down flag kept
      wb(1'b1, swr_pkg::ADDR_CFG, 32'h2);
      wait_rst(50, swr_pkg::IRQ_WDT);
      rd_chk(swr_pkg::ADDR_STATUS, st_word(m_pc, m_to, m_pd));
      irq_chk();
      rd_chk(5'h1c, 32'h0);
      tally_and_finish();
   end
endmodule : tb_sleep_wakeup_reset_cause
`default_nettype wire
